// ==== hdl/lbs_pkg.sv ====
// Shared constants and types for the lamp ballast mode sequencer
package lbs_pkg;

    // Clock rate and timing base
    localparam int CLK_MHZ = 40;
    localparam int TIME_W = 16;

    // Oscillator phase lengths in their own unit, then in clock cycles
    localparam int PREHEAT_ON_NS = 10000;
    localparam int RUN_ON_NS = 16000;
    localparam int DEAD_NS = 1000;
    localparam logic [TIME_W-1:0] PREHEAT_ON_CYC = TIME_W'((PREHEAT_ON_NS * CLK_MHZ + 999) / 1000);
    localparam logic [TIME_W-1:0] RUN_ON_CYC = TIME_W'((RUN_ON_NS * CLK_MHZ + 999) / 1000);
    localparam logic [TIME_W-1:0] DEAD_CYC = TIME_W'((DEAD_NS * CLK_MHZ + 999) / 1000);

    // On-time growth per oscillator cycle during the ignition sweep
    localparam logic [TIME_W-1:0] SWEEP_STEP_CYC = 16'h0001;

    // Over-current fault counter
    localparam int OC_CNT_W = 5;
    localparam logic [OC_CNT_W-1:0] OC_LIMIT = 5'h19;

    // Operating modes, Gray coded along lockout, preheat, ignition, run, fault
    typedef enum logic [2:0] {
        MODE_LOCKOUT  = 3'h0,
        MODE_PREHEAT  = 3'h1,
        MODE_IGNITION = 3'h3,
        MODE_RUN      = 3'h2,
        MODE_FAULT    = 3'h6
    } lbs_mode_type;

    // Comparator flags from the analog sense circuits, all active high
    typedef struct packed {
        logic supply_start;
        logic supply_off;
        logic sd_above_5v0;
        logic sd_above_5v2;
        logic cs_over;
        logic eol_high;
        logic eol_low;
        logic bus_under;
        logic timer_10v;
        logic timer_12v;
    } lbs_sense_type;

    localparam int SENSE_W = $bits(lbs_sense_type);
    localparam logic [SENSE_W-1:0] SENSE_RST = 10'h000;

endpackage

// ==== hdl/lbs_sync.sv ====
// Three-stage synchroniser with agreement filter for comparator flags
`timescale 1ns/1ps
module lbs_sync
    import lbs_pkg::*;
#(
    parameter int WIDTH = SENSE_W,
    parameter logic [WIDTH-1:0] RST_VAL = '0
)
(
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] st1_q, st2_q, st3_q, out_q;
    logic [WIDTH-1:0] out_d;

    // A bit changes only once stages two and three agree
    always_comb begin
        out_d = out_q;
        for (int i = 0; i < WIDTH; i++) begin
            if (st2_q[i] == st3_q[i]) begin
                out_d[i] = st2_q[i];
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            st1_q <= RST_VAL;
            st2_q <= RST_VAL;
            st3_q <= RST_VAL;
            out_q <= RST_VAL;
        end else if (clk_en) begin
            st1_q <= async_in;
            st2_q <= st1_q;
            st3_q <= st2_q;
            out_q <= out_d;
        end
    end

    assign sync_out = out_q;

endmodule

// ==== hdl/lbs_osc.sv ====
// Half-bridge oscillator: alternating on-phases separated by dead time
`timescale 1ns/1ps
module lbs_osc
    import lbs_pkg::*;
#(
    parameter int TW = TIME_W
)
(
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic run,
    input wire logic [TW-1:0] on_len,
    input wire logic [TW-1:0] dead_len,
    output logic low_on,
    output logic high_on,
    output logic low_end,
    output logic cycle_end
);

    logic [TW-1:0] cnt_q, cnt_d;
    logic dead_q, dead_d;
    logic high_q, high_d;
    logic last;

    // Stopped position is the start of a low-side on-phase
    always_comb begin
        cnt_d = cnt_q;
        dead_d = dead_q;
        high_d = high_q;
        last = dead_q ? (cnt_q >= dead_len - 1'b1) : (cnt_q >= on_len - 1'b1);
        if (!run) begin
            cnt_d = '0;
            dead_d = 1'b0;
            high_d = 1'b0;
        end else if (last) begin
            cnt_d = '0;
            dead_d = !dead_q;
            if (dead_q) begin
                high_d = !high_q;
            end
        end else begin
            cnt_d = cnt_q + 1'b1;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            cnt_q <= '0;
            dead_q <= 1'b0;
            high_q <= 1'b0;
        end else if (clk_en) begin
            cnt_q <= cnt_d;
            dead_q <= dead_d;
            high_q <= high_d;
        end
    end

    assign low_on = !dead_q && !high_q;
    assign high_on = !dead_q && high_q;
    assign low_end = run && last && !dead_q && !high_q;
    assign cycle_end = run && last && dead_q;

endmodule

// ==== hdl/lbs_ballast_seq.sv ====
// Ballast mode sequencer: modes, gate drive, fault counting and latching
`timescale 1ns/1ps
// Overview of operation
// - Lockout: gates low, oscillator stopped, timer reset
// - Start needs supply threshold and shutdown below 5.0V
// - First gate pulse after lockout is low side
// - Preheat: alternate sides, equal on-times except the first low pulse (one cycle longer), dead time
// - Each cycle: on-phase then dead phase, both low
// - Timer above 10V moves preheat into ignition
// - Ignition sweeps frequency gradually down to run
// - Preheat/ignition: over 25 consecutive over-currents means fault
// - Count over-current only during low-side on-time
// - Run: one over-current pulse means immediate fault
// - Run: lifetime sense above 3V/below 1V faults
// - Fault latches high, low and boost gates low
// - Fault holds preheat timer in reset
// - Fault keeps the oscillator stopped
// - Fault exits to lockout on supply off/5.2V
// - After fault, restart enters preheat under start conditions
// - Bus under 3.0V: gates low, back to lockout
// - Lifetime detection enabled only above 12V timer level
module lbs_ballast_seq
    import lbs_pkg::*;
#(
    parameter logic [TIME_W-1:0] PREHEAT_ON = PREHEAT_ON_CYC,
    parameter logic [TIME_W-1:0] RUN_ON = RUN_ON_CYC,
    parameter logic [TIME_W-1:0] DEAD_LEN = DEAD_CYC,
    parameter logic [TIME_W-1:0] SWEEP_STEP = SWEEP_STEP_CYC,
    parameter logic [OC_CNT_W-1:0] OC_MAX = OC_LIMIT
)
(
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire lbs_sense_type sense,
    input wire logic boost_request,
    output logic high_side_gate,
    output logic low_side_gate,
    output logic boost_switch_gate,
    output logic preheat_timer_reset,
    output logic oscillator_stop,
    output lbs_mode_type mode,
    output logic [OC_CNT_W-1:0] oc_count
);

    function automatic logic is_running(input lbs_mode_type m);
        return (m == MODE_PREHEAT) || (m == MODE_IGNITION) || (m == MODE_RUN);
    endfunction

    function automatic logic is_counting(input lbs_mode_type m);
        return (m == MODE_PREHEAT) || (m == MODE_IGNITION);
    endfunction

    logic [SENSE_W-1:0] sense_bits;
    lbs_sense_type s;
    lbs_mode_type state_q, state_d;
    logic [OC_CNT_W-1:0] oc_cnt_q, oc_cnt_d;
    logic oc_seen_q, oc_seen_d;
    logic [TIME_W-1:0] on_len_q, on_len_d;
    logic high_side_q, high_side_d;
    logic low_side_q, low_side_d;
    logic boost_q, boost_d;
    logic ph_rst_q, ph_rst_d;
    logic osc_stop_q, osc_stop_d;
    logic osc_low_on, osc_high_on, osc_low_end, osc_cycle_end;
    logic lock_req, start_ok, oc_trip, eol_trip, oc_hit;

    // Comparator flags pass the filtered synchroniser first
    lbs_sync #(
        .WIDTH(SENSE_W),
        .RST_VAL(SENSE_RST)
    ) u_sync (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .clk_en(clk_en),
        .async_in(sense),
        .sync_out(sense_bits)
    );

    assign s = lbs_sense_type'(sense_bits);

    // Same on-length serves both sides, so duty stays balanced
    lbs_osc #(
        .TW(TIME_W)
    ) u_osc (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .clk_en(clk_en),
        .run(is_running(state_q)),
        .on_len(on_len_q),
        .dead_len(DEAD_LEN),
        .low_on(osc_low_on),
        .high_on(osc_high_on),
        .low_end(osc_low_end),
        .cycle_end(osc_cycle_end)
    );

    // Mode sequencing
    always_comb begin
        lock_req = s.bus_under || s.sd_above_5v2 || s.supply_off;
        start_ok = s.supply_start && !s.sd_above_5v0 && !lock_req;
        oc_trip = oc_cnt_q > OC_MAX;
        eol_trip = s.timer_12v && (s.eol_high || s.eol_low);
        state_d = state_q;
        if (lock_req) begin
            state_d = MODE_LOCKOUT;
        end else begin
            unique case (state_q)
                MODE_LOCKOUT: begin
                    if (start_ok) begin
                        state_d = MODE_PREHEAT;
                    end
                end
                MODE_PREHEAT: begin
                    if (oc_trip) begin
                        state_d = MODE_FAULT;
                    end else if (s.timer_10v) begin
                        state_d = MODE_IGNITION;
                    end
                end
                MODE_IGNITION: begin
                    if (oc_trip) begin
                        state_d = MODE_FAULT;
                    end else if (on_len_q >= RUN_ON) begin
                        state_d = MODE_RUN;
                    end
                end
                MODE_RUN: begin
                    if (s.cs_over || eol_trip) begin
                        state_d = MODE_FAULT;
                    end
                end
                MODE_FAULT: begin
                    state_d = MODE_FAULT;
                end
                default: begin
                    state_d = MODE_LOCKOUT;
                end
            endcase
        end
    end

    // Over-current counting; an event at the end of an on-time still counts
    always_comb begin
        oc_seen_d = oc_seen_q;
        oc_cnt_d = oc_cnt_q;
        oc_hit = oc_seen_q || (s.cs_over && osc_low_on);
        // Leaving the counting modes clears at once, so fault and run start at zero
        if (!is_counting(state_q) || !is_counting(state_d)) begin
            oc_seen_d = 1'b0;
            oc_cnt_d = '0;
        end else if (osc_low_end) begin
            oc_seen_d = 1'b0;
            if (oc_hit) begin
                if (oc_cnt_q <= OC_MAX) begin
                    oc_cnt_d = oc_cnt_q + 1'b1;
                end
            end else begin
                oc_cnt_d = '0;
            end
        end else begin
            oc_seen_d = oc_hit;
        end
    end

    // Ignition lengthens the on-time step by step toward the run value
    always_comb begin
        on_len_d = on_len_q;
        if (state_q == MODE_IGNITION) begin
            if (osc_cycle_end && (on_len_q < RUN_ON)) begin
                if ((RUN_ON - on_len_q) > SWEEP_STEP) begin
                    on_len_d = on_len_q + SWEEP_STEP;
                end else begin
                    on_len_d = RUN_ON;
                end
            end
        end else if (state_q != MODE_RUN) begin
            on_len_d = PREHEAT_ON;
        end
    end

    // Outputs follow the next mode, so a trip blanks the gates on the same edge
    always_comb begin
        high_side_d = is_running(state_d) && osc_high_on;
        low_side_d = is_running(state_d) && osc_low_on;
        boost_d = is_running(state_d) && boost_request;
        ph_rst_d = !is_running(state_d);
        osc_stop_d = !is_running(state_d);
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            state_q <= MODE_LOCKOUT;
            oc_cnt_q <= '0;
            oc_seen_q <= 1'b0;
            on_len_q <= PREHEAT_ON;
            high_side_q <= 1'b0;
            low_side_q <= 1'b0;
            boost_q <= 1'b0;
            ph_rst_q <= 1'b1;
            osc_stop_q <= 1'b1;
        end else if (clk_en) begin
            state_q <= state_d;
            oc_cnt_q <= oc_cnt_d;
            oc_seen_q <= oc_seen_d;
            on_len_q <= on_len_d;
            high_side_q <= high_side_d;
            low_side_q <= low_side_d;
            boost_q <= boost_d;
            ph_rst_q <= ph_rst_d;
            osc_stop_q <= osc_stop_d;
        end
    end

    assign high_side_gate = high_side_q;
    assign low_side_gate = low_side_q;
    assign boost_switch_gate = boost_q;
    assign preheat_timer_reset = ph_rst_q;
    assign oscillator_stop = osc_stop_q;
    assign mode = state_q;
    assign oc_count = oc_cnt_q;

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);

    property p_lockout_quiet;
        (state_q == MODE_LOCKOUT) |-> (!high_side_q && !low_side_q && osc_stop_q && ph_rst_q);
    endproperty
    a_lockout_quiet: assert property (p_lockout_quiet)
        else $error("lockout with gate active or timer released");

    property p_start;
        (state_q == MODE_LOCKOUT && clk_en && start_ok) |=> (state_q == MODE_PREHEAT);
    endproperty
    a_start: assert property (p_start)
        else $error("start conditions met but preheat not entered");

    property p_first_low;
        ($past(state_q) == MODE_LOCKOUT && state_q == MODE_PREHEAT) |-> (low_side_q && !high_side_q);
    endproperty
    a_first_low: assert property (p_first_low)
        else $error("first pulse after lockout is not low side");

    property p_dead_time;
        ($fell(low_side_q) || $fell(high_side_q)) |-> (!low_side_q && !high_side_q) [*2];
    endproperty
    a_dead_time: assert property (p_dead_time)
        else $error("no dead time after an on-phase");

    property p_no_overlap;
        !(high_side_q && low_side_q);
    endproperty
    a_no_overlap: assert property (p_no_overlap)
        else $error("both gates high");

    property p_preheat_to_ign;
        (state_q == MODE_PREHEAT && clk_en && s.timer_10v && !oc_trip && !lock_req)
            |=> (state_q == MODE_IGNITION);
    endproperty
    a_preheat_to_ign: assert property (p_preheat_to_ign)
        else $error("timer level reached but ignition not entered");

    property p_sweep_mono;
        ($past(state_q) == MODE_IGNITION && state_q == MODE_IGNITION)
            |-> (on_len_q >= $past(on_len_q) && on_len_q <= RUN_ON);
    endproperty
    a_sweep_mono: assert property (p_sweep_mono)
        else $error("ignition sweep not monotonic");

    property p_count_fault;
        (is_counting(state_q) && clk_en && oc_trip && !lock_req) |=> (state_q == MODE_FAULT);
    endproperty
    a_count_fault: assert property (p_count_fault)
        else $error("count over limit without fault");

    property p_count_step;
        (is_counting(state_q) && is_counting(state_d) && clk_en && !osc_low_end)
            |=> (oc_cnt_q == $past(oc_cnt_q));
    endproperty
    a_count_step: assert property (p_count_step)
        else $error("counter moved outside a low-side on-time end");

    property p_run_oc;
        (state_q == MODE_RUN && clk_en && s.cs_over && !lock_req) |=> (state_q == MODE_FAULT);
    endproperty
    a_run_oc: assert property (p_run_oc)
        else $error("run over-current did not fault");

    property p_eol;
        (state_q == MODE_RUN && clk_en && !lock_req && s.timer_12v && (s.eol_high || s.eol_low))
            |=> (state_q == MODE_FAULT);
    endproperty
    a_eol: assert property (p_eol)
        else $error("lifetime fault not taken");

    property p_eol_gate;
        (state_q == MODE_RUN && clk_en && !lock_req && !s.timer_12v && !s.cs_over)
            |=> (state_q == MODE_RUN);
    endproperty
    a_eol_gate: assert property (p_eol_gate)
        else $error("run left with lifetime detection disabled");

    property p_fault_latch;
        (state_q == MODE_FAULT)
            |-> (!high_side_q && !low_side_q && !boost_q && ph_rst_q && osc_stop_q && oc_cnt_q == 0);
    endproperty
    a_fault_latch: assert property (p_fault_latch)
        else $error("fault with an output active");

    property p_fault_hold;
        (state_q == MODE_FAULT && clk_en && !lock_req) |=> (state_q == MODE_FAULT);
    endproperty
    a_fault_hold: assert property (p_fault_hold)
        else $error("fault left without exit condition");

    property p_bus_under;
        (clk_en && s.bus_under) |=> (state_q == MODE_LOCKOUT && !high_side_q && !low_side_q);
    endproperty
    a_bus_under: assert property (p_bus_under)
        else $error("bus under-voltage did not force lockout");

    c_reach_run: cover property (state_q == MODE_IGNITION ##1 state_q == MODE_RUN);
    c_count_fault: cover property (is_counting(state_q) ##1 state_q == MODE_FAULT);
    c_fault_restart: cover property (state_q == MODE_FAULT ##1 state_q == MODE_LOCKOUT);
    c_run_eol: cover property (state_q == MODE_RUN && eol_trip ##1 state_q == MODE_FAULT);

endmodule

// ==== test/lbs_far_side_model.sv ====
// Far-side model: half-bridge current sense and preheat capacitor level
`timescale 1ns/1ps
module lbs_far_side_model
    import lbs_pkg::*;
#(
    parameter int T10 = 1500,
    parameter int T12 = 1540
)
(
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic high_side_gate,
    input wire logic low_side_gate,
    input wire logic preheat_timer_reset,
    input wire logic [1:0] oc_sel,
    output lbs_sense_type sense
);
    logic [11:0] level_q;
    logic [11:0] level_d;
    logic cs_q;
    logic cs_d;

    always_comb begin
        // Capacitor discharged while held in reset, otherwise ramps and clamps
        level_d = level_q + ((level_q == 12'hFFF) ? 12'h000 : 12'h001);
        if (preheat_timer_reset) begin
            level_d = 12'h000;
        end
        // 1: hard switching in the low-side switch, 2: current while high side conducts
        cs_d = (oc_sel == 2'h1 && low_side_gate) || (oc_sel == 2'h2 && high_side_gate);
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            level_q <= 12'h000;
            cs_q <= 1'b0;
        end else begin
            level_q <= level_d;
            cs_q <= cs_d;
        end
    end

    always_comb begin
        sense = '0;
        sense.cs_over = cs_q;
        sense.timer_10v = int'(level_q) >= T10;
        sense.timer_12v = int'(level_q) >= T12;
    end
endmodule

// ==== test/lamp_ballast_mode_sequencer_tb.sv ====
// Self-checking testbench for the lamp ballast mode sequencer
`timescale 1ns/1ps
module lamp_ballast_mode_sequencer_tb;
    import lbs_pkg::*;
    localparam logic [TIME_W-1:0] P_ON = 16'h0008;
    localparam logic [TIME_W-1:0] R_ON = 16'h0010;
    // Dead time longer than the sense latency, so high-side current never spills into low on-time
    localparam logic [TIME_W-1:0] D_LEN = 16'h0008;
    typedef struct packed {
        logic [SENSE_W-1:0] s;
        lbs_mode_type m;
    } lbs_row_type;
    lbs_row_type rows [8];
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic [SENSE_W-1:0] tb_sense = 10'h000;
    logic [1:0] oc_sel = 2'h0;
    logic boost_request = 1'b1;
    lbs_sense_type part_sense;
    lbs_sense_type sense;
    logic high_side_gate;
    logic low_side_gate;
    logic boost_switch_gate;
    logic preheat_timer_reset;
    logic oscillator_stop;
    lbs_mode_type mode;
    logic [OC_CNT_W-1:0] oc_count;
    int n_mismatch = 0;
    int checked = 0;
    int n;
    int k;
    logic prev;

    assign sense = lbs_sense_type'(tb_sense | part_sense);

    lbs_ballast_seq #(.PREHEAT_ON(P_ON), .RUN_ON(R_ON), .DEAD_LEN(D_LEN),
        .SWEEP_STEP(16'h0002), .OC_MAX(5'h19)) dut (
        .clk_sys(clk_sys), .rst_n(rst_n), .clk_en(1'b1), .sense(sense),
        .boost_request(boost_request), .high_side_gate(high_side_gate),
        .low_side_gate(low_side_gate), .boost_switch_gate(boost_switch_gate),
        .preheat_timer_reset(preheat_timer_reset), .oscillator_stop(oscillator_stop),
        .mode(mode), .oc_count(oc_count));

    lbs_far_side_model #(.T10(1500), .T12(1800)) far (
        .clk_sys(clk_sys), .rst_n(rst_n), .high_side_gate(high_side_gate),
        .low_side_gate(low_side_gate), .preheat_timer_reset(preheat_timer_reset),
        .oc_sel(oc_sel), .sense(part_sense));

    initial begin
        forever #12.5 clk_sys = ~clk_sys;
    end

    task automatic results();
        $display("Comparisons %0d, mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic cmp_val(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic cmp_mode(input lbs_mode_type got, input lbs_mode_type exp);
        cmp_val(16'(got), 16'(exp));
    endtask

    // Waits at falling edges for a mode, counting cycles; a spent bound ends the run
    task automatic wait_mode(input lbs_mode_type m, input int lim, output int cnt);
        cnt = 0;
        while (mode !== m) begin
            if (cnt >= lim) begin
                n_mismatch++;
                $display("MISMATCH t=%0t got=%h exp=%h", $time, mode, m);
                results();
            end
            cnt++;
            @(negedge clk_sys);
        end
    endtask

    // Length in cycles of the current gate pattern {high, low}
    task automatic phase_len(input logic [1:0] g, output int cnt);
        cnt = 0;
        while ({high_side_gate, low_side_gate} === g && cnt < 5000) begin
            cnt++;
            @(negedge clk_sys);
        end
    endtask

    // Waits at falling edges for a gate pattern {high, low}; a spent bound ends the run
    task automatic wait_gates(input logic [1:0] g, input int lim);
        int c;
        c = 0;
        while ({high_side_gate, low_side_gate} !== g) begin
            if (c >= lim) begin
                n_mismatch++;
                $display("MISMATCH t=%0t got=%h exp=%h", $time, {high_side_gate, low_side_gate}, g);
                results();
            end
            c++;
            @(negedge clk_sys);
        end
    endtask

    task automatic drive_run();
        tb_sense = 10'h200;
        wait_mode(MODE_PREHEAT, 20, n);
        wait_mode(MODE_IGNITION, 2000, n);
        cmp_val(16'(n >= 1500), 16'h0001);
        wait_mode(MODE_RUN, 500, n);
    endtask

    task automatic recover();
        tb_sense = 10'h240;
        wait_mode(MODE_LOCKOUT, 10, n);
        tb_sense = 10'h200;
        wait_mode(MODE_PREHEAT, 10, n);
    endtask

    task automatic check_fault();
        repeat (20) @(negedge clk_sys);
        cmp_mode(mode, MODE_FAULT);
        cmp_val({high_side_gate, low_side_gate, boost_switch_gate, preheat_timer_reset,
            oscillator_stop}, 16'h0003);
    endtask

    initial begin
        // Start-condition table: sense flags, settled mode
        rows[0] = '{10'h280, MODE_LOCKOUT};
        rows[1] = '{10'h200, MODE_PREHEAT};
        rows[2] = '{10'h210, MODE_PREHEAT};
        rows[3] = '{10'h204, MODE_LOCKOUT};
        rows[4] = '{10'h200, MODE_PREHEAT};
        rows[5] = '{10'h300, MODE_LOCKOUT};
        rows[6] = '{10'h200, MODE_PREHEAT};
        rows[7] = '{10'h240, MODE_LOCKOUT};
        repeat (12) @(negedge clk_sys);
        cmp_val({high_side_gate, low_side_gate, preheat_timer_reset, oscillator_stop,
            12'(oc_count)}, 16'h3000);
        rst_n = 1'b1;
        for (int i = 0; i < 8; i++) begin
            tb_sense = rows[i].s;
            repeat (8) @(negedge clk_sys);
            cmp_mode(mode, rows[i].m);
            if (rows[i].m == MODE_LOCKOUT) begin
                cmp_val({high_side_gate, low_side_gate, preheat_timer_reset,
                    oscillator_stop}, 16'h0003);
            end else begin
                cmp_val(16'(preheat_timer_reset), 16'h0000);
            end
        end
        // First pulse low side, then dead, high, dead, low
        tb_sense = 10'h200;
        wait_mode(MODE_PREHEAT, 10, n);
        cmp_val(16'({high_side_gate, low_side_gate}), 16'h0001);
        phase_len(2'b01, n);
        cmp_val(16'(n), P_ON + 16'h0001);
        phase_len(2'b00, n);
        cmp_val(16'(n), D_LEN);
        phase_len(2'b10, n);
        cmp_val(16'(n), P_ON);
        phase_len(2'b00, n);
        cmp_val(16'(n), D_LEN);
        phase_len(2'b01, n);
        cmp_val(16'(n), P_ON);
        // Over-current only while the high side conducts is not counted
        oc_sel = 2'h2;
        repeat (200) @(negedge clk_sys);
        cmp_val(16'(oc_count), 16'h0000);
        cmp_mode(mode, MODE_PREHEAT);
        oc_sel = 2'h1;
        k = 0;
        while (oc_count !== 5'h03 && k < 200) begin
            k++;
            @(negedge clk_sys);
        end
        cmp_val(16'(oc_count), 16'h0003);
        oc_sel = 2'h0;
        repeat (40) @(negedge clk_sys);
        cmp_val(16'(oc_count), 16'h0000);
        // Count low pulses from a clean start up to the fault
        wait_gates(2'b10, 100);
        oc_sel = 2'h1;
        k = 0;
        n = 0;
        prev = 1'b0;
        while (mode !== MODE_FAULT && n < 2000) begin
            if (low_side_gate === 1'b1 && prev === 1'b0) begin
                k++;
            end
            prev = low_side_gate;
            n++;
            @(negedge clk_sys);
        end
        cmp_val(16'(k), 16'h001A);
        check_fault();
        cmp_val(16'(oc_count), 16'h0000);
        oc_sel = 2'h0;
        recover();
        // Full start to run; lifetime sense ignored until the timer passes its enable level
        drive_run();
        tb_sense = 10'h210;
        repeat (8) @(negedge clk_sys);
        cmp_mode(mode, MODE_RUN);
        wait_gates(2'b10, 100);
        wait_gates(2'b01, 100);
        phase_len(2'b01, n);
        cmp_val(16'(n), R_ON);
        cmp_val(16'(boost_switch_gate), 16'h0001);
        boost_request = 1'b0;
        repeat (2) @(negedge clk_sys);
        cmp_val(16'(boost_switch_gate), 16'h0000);
        boost_request = 1'b1;
        cmp_val(16'(oc_count), 16'h0000);
        wait_mode(MODE_FAULT, 400, n);
        check_fault();
        recover();
        // Single over-current pulse in run faults at once
        drive_run();
        repeat (40) @(negedge clk_sys);
        oc_sel = 2'h2;
        wait_mode(MODE_FAULT, 40, n);
        check_fault();
        oc_sel = 2'h0;
        // Bus under-voltage from fault returns to lockout with gates low
        tb_sense = 10'h204;
        wait_mode(MODE_LOCKOUT, 8, n);
        cmp_val({high_side_gate, low_side_gate, boost_switch_gate}, 16'h0000);
        results();
    end
endmodule
